// *** fbt_consts.svh ***
// Register indices, field positions, reset values for the fine baud timer.
// Assumes a 32-bit AXI4-Lite bus; byte address is four times the index.
`ifndef FBT_CONSTS_SVH
`define FBT_CONSTS_SVH

// Channel base indices and per-register index offsets
`define FBT_IDX_CH0_BASE   16'h4200
`define FBT_IDX_CH1_BASE   16'h4280
`define FBT_IDX_BASE_MASK  16'hff80
`define FBT_OFF_CLK        7'h00
`define FBT_OFF_TR         7'h02
`define FBT_OFF_TC         7'h04
`define FBT_OFF_CTL        7'h06
`define FBT_OFF_INT        7'h08

// Field positions
`define FBT_CTL_RUN_BIT    0
`define FBT_CTL_PRESET_BIT 1
`define FBT_CTL_ONESHOT_BIT 4
`define FBT_CTL_FINE_LSB   8
`define FBT_INT_FLAG_BIT   0
`define FBT_INT_EN_BIT     8

// Reset values and special codes
`define FBT_RST_DIV        4'h0
`define FBT_RST_RELOAD     16'h0000
`define FBT_RST_COUNT      16'hffff
`define FBT_RST_FINE       4'h0
`define FBT_DIV_RESERVED   4'hf

// AXI responses
`define FBT_RESP_OKAY      2'b00
`define FBT_RESP_SLVERR    2'b10

`endif

// *** fbt_pkg.sv ***
// Types shared by the fine baud timer.
// Assumes the constants header is included by the design file.
package fbt_pkg;

    // Register selected by an address
    typedef enum logic [2:0] {
        FBT_R_CLK  = 3'h0,
        FBT_R_TR   = 3'h1,
        FBT_R_TC   = 3'h3,
        FBT_R_CTL  = 3'h2,
        FBT_R_INT  = 3'h6,
        FBT_R_NONE = 3'h7
    } fbt_reg_t;

    // Decoded address
    typedef struct packed {
        logic     hit;
        logic     ch;
        fbt_reg_t r;
    } fbt_dec_t;

endpackage

// *** fbt_timer.sv ***
// Two-channel 16-bit reloadable down timer with fine delay insertion.
// Assumes one 40 MHz clock, an AXI4-Lite master on the same clock,
// and an interrupt controller that samples level requests.
`timescale 1ns/1ps
`include "fbt_consts.svh"

module fbt_timer
    import fbt_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    // AXI4-Lite read address
    input  wire logic [31:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // Per-channel outputs
    output logic [1:0]       underflow_out,
    output logic [1:0]       serial_clk_out,
    output logic [1:0]       irq_out
);

    // Address decode, shared by read and write paths
    function automatic fbt_dec_t decode(input logic [31:0] a);
        fbt_dec_t   d;
        logic [15:0] idx;
        logic [15:0] base;
        idx    = a[17:2];
        base   = idx & `FBT_IDX_BASE_MASK;
        d.ch   = (base == `FBT_IDX_CH1_BASE);
        d.r    = FBT_R_NONE;
        case (idx[6:0])
            `FBT_OFF_CLK: d.r = FBT_R_CLK;
            `FBT_OFF_TR:  d.r = FBT_R_TR;
            `FBT_OFF_TC:  d.r = FBT_R_TC;
            `FBT_OFF_CTL: d.r = FBT_R_CTL;
            `FBT_OFF_INT: d.r = FBT_R_INT;
            default:      d.r = FBT_R_NONE;
        endcase
        d.hit  = (a[31:18] == 14'h0) && (d.r != FBT_R_NONE)
               && ((base == `FBT_IDX_CH0_BASE) || (base == `FBT_IDX_CH1_BASE));
        return d;
    endfunction

    // Fine delay pattern: bit k set delays underflow number k+1
    function automatic logic [15:0] fine_pattern(input logic [3:0] sel);
        case (sel)
            4'h0:    fine_pattern = 16'h0000;
            4'h1:    fine_pattern = 16'h8000;
            4'h2:    fine_pattern = 16'h8100;
            4'h3:    fine_pattern = 16'h8880;
            4'h4:    fine_pattern = 16'h8888;
            4'h5:    fine_pattern = 16'ha888;
            4'h6:    fine_pattern = 16'ha8a8;
            4'h7:    fine_pattern = 16'haaa8;
            4'h8:    fine_pattern = 16'haaaa;
            4'h9:    fine_pattern = 16'heaaa;
            4'ha:    fine_pattern = 16'heaea;
            4'hb:    fine_pattern = 16'heeea;
            4'hc:    fine_pattern = 16'heeee;
            4'hd:    fine_pattern = 16'hfeee;
            4'he:    fine_pattern = 16'hfefe;
            default: fine_pattern = 16'hfffe;
        endcase
    endfunction

    // Bus-side state
    logic        aw_full_reg;
    logic [31:0] aw_addr_reg;
    logic        w_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    // Per-channel state
    logic [3:0]  clk_div_sel_reg    [2];
    logic [15:0] reload_reg         [2];
    logic [15:0] count_reg          [2];
    logic        timer_run_reg      [2];
    logic        one_shot_sel_reg   [2];
    logic [3:0]  fine_delay_sel_reg [2];
    logic        underflow_irq_en_reg   [2];
    logic        underflow_irq_flag_reg [2];
    logic [13:0] prescale_reg       [2];
    logic [3:0]  uf_index_reg       [2];
    logic        delay_pend_reg     [2];
    logic        uf_pulse_reg       [2];
    logic        ser_clk_reg        [2];

    // Write commit once both address and data are held
    wire         wr_commit = aw_full_reg && w_full_reg && !bvalid_reg;
    fbt_dec_t    wr_dec;
    fbt_dec_t    rd_dec;
    assign wr_dec = decode(aw_addr_reg);
    assign rd_dec = decode(s_axi_araddr_in);
    wire         wr_lo = wr_commit && wr_dec.hit && w_strb_reg[0];
    wire         wr_hi = wr_commit && wr_dec.hit && w_strb_reg[1];
    wire         ar_take = s_axi_arvalid_in && !rvalid_reg;

    // Handshake outputs; one outstanding item per channel keeps it simple
    assign s_axi_awready_out = !aw_full_reg;
    assign s_axi_wready_out  = !w_full_reg;
    assign s_axi_arready_out = !rvalid_reg;
    assign s_axi_bvalid_out  = bvalid_reg;
    assign s_axi_bresp_out   = bresp_reg;
    assign s_axi_rvalid_out  = rvalid_reg;
    assign s_axi_rdata_out   = rdata_reg;
    assign s_axi_rresp_out   = rresp_reg;

    // Write address/data capture and response
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 32'h0;
            w_full_reg  <= 1'b0;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `FBT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_in;
            end else if (wr_commit) begin
                aw_full_reg <= 1'b0;
            end
            if (s_axi_wvalid_in && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end else if (wr_commit) begin
                w_full_reg <= 1'b0;
            end
            if (wr_commit) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_dec.hit ? `FBT_RESP_OKAY : `FBT_RESP_SLVERR;
            end else if (s_axi_bready_in) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Read data selection; reserved bits read zero
    logic [15:0] rd_value;
    always_comb begin
        rd_value = 16'h0;
        case (rd_dec.r)
            FBT_R_CLK: rd_value = {12'h0, clk_div_sel_reg[rd_dec.ch]};
            FBT_R_TR:  rd_value = reload_reg[rd_dec.ch];
            FBT_R_TC:  rd_value = count_reg[rd_dec.ch];
            FBT_R_CTL: rd_value = {4'h0, fine_delay_sel_reg[rd_dec.ch], 3'h0,
                                   one_shot_sel_reg[rd_dec.ch], 3'h0,
                                   timer_run_reg[rd_dec.ch]};
            FBT_R_INT: rd_value = {7'h0, underflow_irq_en_reg[rd_dec.ch], 7'h0,
                                   underflow_irq_flag_reg[rd_dec.ch]};
            default:   rd_value = 16'h0;
        endcase
    end

    // Read channel
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0;
            rresp_reg  <= `FBT_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_dec.hit ? {16'h0, rd_value} : 32'h0;
            rresp_reg  <= rd_dec.hit ? `FBT_RESP_OKAY : `FBT_RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            rvalid_reg <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            wire        sel     = (wr_dec.ch == g[0]);
            wire        wr_clk  = wr_lo && sel && (wr_dec.r == FBT_R_CLK);
            wire        wr_tr_l = wr_lo && sel && (wr_dec.r == FBT_R_TR);
            wire        wr_tr_h = wr_hi && sel && (wr_dec.r == FBT_R_TR);
            wire        wr_ctl_l = wr_lo && sel && (wr_dec.r == FBT_R_CTL);
            wire        wr_ctl_h = wr_hi && sel && (wr_dec.r == FBT_R_CTL);
            wire        wr_int_l = wr_lo && sel && (wr_dec.r == FBT_R_INT);
            wire        wr_int_h = wr_hi && sel && (wr_dec.r == FBT_R_INT);
            wire        preset  = wr_ctl_l && w_data_reg[`FBT_CTL_PRESET_BIT];
            wire        clr_flag = wr_int_l && w_data_reg[`FBT_INT_FLAG_BIT];

            // Count clock: prescaler low n bits all ones gives 1/2^n; 0xf never ticks
            wire [13:0] pre_mask = (14'h1 << clk_div_sel_reg[g]) - 14'h1;
            wire        div_ok   = (clk_div_sel_reg[g] != `FBT_DIV_RESERVED);
            wire        tick     = timer_run_reg[g] && div_ok
                                   && ((prescale_reg[g] & pre_mask) == pre_mask);
            wire        at_zero  = (count_reg[g] == 16'h0);
            wire [15:0] pattern  = fine_pattern(fine_delay_sel_reg[g]);
            wire        dly_now  = pattern[uf_index_reg[g]];
            // A delayed zero tick holds the pulse back to the next tick, while the counter waits
            wire        uf_event = tick && (delay_pend_reg[g] || (at_zero && !dly_now));

            // Bus-written configuration
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    clk_div_sel_reg[g]      <= `FBT_RST_DIV;
                    reload_reg[g]           <= `FBT_RST_RELOAD;
                    one_shot_sel_reg[g]     <= 1'b0;
                    fine_delay_sel_reg[g]   <= `FBT_RST_FINE;
                    underflow_irq_en_reg[g] <= 1'b0;
                end else begin
                    if (wr_clk) clk_div_sel_reg[g] <= w_data_reg[3:0];
                    if (wr_tr_l) reload_reg[g][7:0] <= w_data_reg[7:0];
                    if (wr_tr_h) reload_reg[g][15:8] <= w_data_reg[15:8];
                    if (wr_ctl_l) one_shot_sel_reg[g] <= w_data_reg[`FBT_CTL_ONESHOT_BIT];
                    if (wr_ctl_h) fine_delay_sel_reg[g] <= w_data_reg[11:8];
                    if (wr_int_h) underflow_irq_en_reg[g] <= w_data_reg[`FBT_INT_EN_BIT];
                end
            end

            // Run control; a software write wins over the one-shot stop
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    timer_run_reg[g] <= 1'b0;
                end else if (wr_ctl_l) begin
                    timer_run_reg[g] <= w_data_reg[`FBT_CTL_RUN_BIT];
                end else if (uf_event && one_shot_sel_reg[g]) begin
                    timer_run_reg[g] <= 1'b0;
                end
            end

            // Counter, prescaler and fine sequencing
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    prescale_reg[g]   <= 14'h0;
                    count_reg[g]      <= `FBT_RST_COUNT;
                    delay_pend_reg[g] <= 1'b0;
                    uf_index_reg[g]   <= 4'h0;
                end else begin
                    prescale_reg[g] <= timer_run_reg[g] ? prescale_reg[g] + 14'h1 : 14'h0;
                    if (preset) begin
                        count_reg[g]      <= reload_reg[g];
                        delay_pend_reg[g] <= 1'b0;
                        uf_index_reg[g]   <= 4'h0;
                    end else if (tick) begin
                        if (delay_pend_reg[g]) begin
                            delay_pend_reg[g] <= 1'b0;
                        end else if (at_zero) begin
                            count_reg[g]      <= reload_reg[g];
                            delay_pend_reg[g] <= dly_now;
                        end else begin
                            count_reg[g] <= count_reg[g] - 16'h1;
                        end
                        if (uf_event) uf_index_reg[g] <= uf_index_reg[g] + 4'h1;
                    end
                end
            end

            // Pulse, serial clock and sticky flag; set beats a same-cycle clear
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    uf_pulse_reg[g]           <= 1'b0;
                    ser_clk_reg[g]            <= 1'b0;
                    underflow_irq_flag_reg[g] <= 1'b0;
                end else begin
                    uf_pulse_reg[g] <= uf_event;
                    if (uf_event) ser_clk_reg[g] <= !ser_clk_reg[g];
                    if (uf_event) begin
                        underflow_irq_flag_reg[g] <= 1'b1;
                    end else if (clr_flag) begin
                        underflow_irq_flag_reg[g] <= 1'b0;
                    end
                end
            end

            assign underflow_out[g]  = uf_pulse_reg[g];
            assign serial_clk_out[g] = ser_clk_reg[g];
            // Level request, rises with the flag in the pulse cycle
            assign irq_out[g] = underflow_irq_flag_reg[g] && underflow_irq_en_reg[g];
        end
    endgenerate

endmodule

// *** fbt_timer_properties.sv ***
// Concurrent checks on the fine baud timer ports.
// Bound to fbt_timer by the bench; one clock, async active-low reset.
`timescale 1ns/1ps
module fbt_timer_properties (
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        resetn_in,
    // Bus handshakes
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    // Timer outputs
    input wire logic [1:0]  serial_clk_out,
    input wire logic [1:0]  underflow_out,
    input wire logic [1:0]  irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // Transfer clock moves exactly with the underflow pulse
    property p_sclk; (serial_clk_out ^ $past(serial_clk_out)) == underflow_out; endproperty
    a_sclk: assert property (p_sclk) else $error("serial clock out of step");
    // Request only rises with an underflow or an enable write
    property p_irq_rise; ((irq_out & ~$past(irq_out) & ~underflow_out) == 2'b00)
        || $rose(s_axi_bvalid_out); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose alone");
    // Request only drops on a committed write
    property p_irq_fall; (($past(irq_out) & ~irq_out) != 2'b00) |-> $rose(s_axi_bvalid_out); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
    property p_b_hold; s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_w_ans; s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |-> ##2 s_axi_bvalid_out; endproperty
    a_w_ans: assert property (p_w_ans) else $error("write response late");
    property p_r_ans; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
    a_r_ans: assert property (p_r_ans) else $error("read data late");
    // Readies drop after a take and come back at commit, not at bready
    property p_w_block; s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |=> !s_axi_awready_out && !s_axi_wready_out; endproperty
    a_w_block: assert property (p_w_block) else $error("write taken twice");
    property p_resp; s_axi_bvalid_out |-> s_axi_bresp_out inside {2'b00, 2'b10}; endproperty
    a_resp: assert property (p_resp) else $error("bad write response code");
endmodule

// *** fbt_serial_sink.sv ***
// Serial unit stand-in: watches each channel transfer clock.
// Reports last gap between clock edges, in clocks, and an edge count.
`timescale 1ns/1ps
module fbt_serial_sink (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // Transfer clocks from the timer
    input  wire logic [1:0]  serial_clk_in,
    // Observations
    output logic      [31:0] gap0_out,
    output logic      [31:0] gap1_out,
    output logic      [31:0] count0_out,
    output logic      [31:0] count1_out
);
    logic [1:0]  last_reg;
    logic [31:0] run_reg [2];
    logic [31:0] gap_reg [2];
    logic [31:0] cnt_reg [2];
    // Either clock edge is one underflow; the clock only moves on them
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            last_reg <= 2'b00;
            run_reg  <= '{32'h1, 32'h1};
            gap_reg  <= '{32'h0, 32'h0};
            cnt_reg  <= '{32'h0, 32'h0};
        end else begin
            last_reg <= serial_clk_in;
            for (int i = 0; i < 2; i++) begin
                if (serial_clk_in[i] != last_reg[i]) begin
                    gap_reg[i] <= run_reg[i];
                    run_reg[i] <= 32'h1;
                    cnt_reg[i] <= cnt_reg[i] + 32'h1;
                end else begin
                    run_reg[i] <= run_reg[i] + 32'h1;
                end
            end
        end
    end
    assign gap0_out   = gap_reg[0];
    assign gap1_out   = gap_reg[1];
    assign count0_out = cnt_reg[0];
    assign count1_out = cnt_reg[1];
endmodule

// *** fbt_timer_bench.sv ***
// Self-checking bench for the two-channel fine baud timer.
// Software role over AXI4-Lite at 40 MHz; a serial sink times the clocks.
`timescale 1ns/1ps
`include "fbt_consts.svh"
module fbt_timer_bench;
    logic        clk_in, resetn_in, s_axi_awvalid_in, s_axi_awready_out;
    logic        s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
    logic        s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
    logic [31:0] s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, underflow_out, serial_clk_out, irq_out;
    logic [31:0] gap0, gap1, count0, count1;
    int          num_errors, n_compared;
    // Delayed positions per fine code, bit k-1 for underflow k
    logic [15:0] fine_mask [16] = '{16'h0000, 16'h8000, 16'h8100, 16'h8880, 16'h8888,
        16'ha888, 16'ha8a8, 16'haaa8, 16'haaaa, 16'heaaa, 16'heaea, 16'heeea, 16'heeee,
        16'hfeee, 16'hfefe, 16'hfffe};
    // Period cases: channel, divider code, reload
    logic        ch_t [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [3:0]  n_t  [4] = '{4'h0, 4'h2, 4'h1, 4'he};
    logic [15:0] r_t  [4] = '{16'h0003, 16'h0005, 16'h0007, 16'h0000};

    fbt_timer DUT (.clk_in, .resetn_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
        .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
        .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
        .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .underflow_out,
        .serial_clk_out, .irq_out);
    fbt_serial_sink u_sink (.clk_in, .resetn_in, .serial_clk_in(serial_clk_out),
        .gap0_out(gap0), .gap1_out(gap1), .count0_out(count0), .count1_out(count1));

    always #12.5 clk_in = ~clk_in;

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic hang;
        num_errors++;
        $display("MISMATCH wait expected answer seen none");
        end_sim();
    endtask
    // Byte address is four times the register index
    function automatic logic [31:0] ad(input logic ch, input logic [6:0] off);
        logic [15:0] idx;
        idx = (ch ? `FBT_IDX_CH1_BASE : `FBT_IDX_CH0_BASE) + {9'h000, off};
        return {14'h0000, idx, 2'b00};
    endfunction
    // Ready for the answer only after it shows, so holds get exercised
    task automatic wr(input logic [31:0] a, input logic [15:0] d,
                      input logic [1:0] er = `FBT_RESP_OKAY);
        int k;
        @(posedge clk_in);
        s_axi_awaddr_in  <= a;
        s_axi_wdata_in   <= {16'h0000, d};
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in  <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_in);
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
            if (s_axi_bvalid_out && s_axi_bready_in) break;
            if (s_axi_bvalid_out) s_axi_bready_in <= 1'b1;
        end
        s_axi_bready_in <= 1'b0;
        chk("write resp", {30'h0, s_axi_bresp_out}, {30'h0, er});
        if (k == 40) hang();
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge clk_in);
        s_axi_araddr_in  <= a;
        s_axi_arvalid_in <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_in);
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
            if (s_axi_rvalid_out && s_axi_rready_in) break;
            if (s_axi_rvalid_out) s_axi_rready_in <= 1'b1;
        end
        s_axi_rready_in <= 1'b0;
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        if (k == 40) hang();
    endtask
    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, d, exp);
    endtask
    // Stop, then configure, preset and run in the order software must use
    task automatic setup(input logic ch, input logic [3:0] n, input logic [15:0] rl,
                         input logic [15:0] mode);
        wr(ad(ch, `FBT_OFF_CTL), 16'h0000);
        wr(ad(ch, `FBT_OFF_CLK), {12'h000, n});
        wr(ad(ch, `FBT_OFF_TR), rl);
        wr(ad(ch, `FBT_OFF_CTL), mode | 16'h0002);
        wr(ad(ch, `FBT_OFF_CTL), mode | 16'h0001);
    endtask
    // Next transfer clock edge, bounded by the longest period used
    task automatic wait_uf(input logic ch, output logic [31:0] g);
        logic [31:0] c;
        int          k;
        c = ch ? count1 : count0;
        for (k = 0; k < 20000; k++) begin
            @(posedge clk_in);
            if ((ch ? count1 : count0) !== c) break;
        end
        g = ch ? gap1 : gap0;
        if (k == 20000) hang();
    endtask

    initial begin
        logic [31:0] d;
        logic [31:0] g;
        logic [1:0]  r;
        int          i;
        int          k;
        clk_in = 1'b0;
        resetn_in = 1'b0;
        {s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in} = '0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} = 3'b000;
        {s_axi_bready_in, s_axi_rready_in} = 2'b00;
        s_axi_wstrb_in = 4'hf;
        num_errors = 0;
        n_compared = 0;
        repeat (4) @(posedge clk_in);
        resetn_in <= 1'b1;
        for (i = 0; i < 2; i++) begin
            rdc("count", ad(i == 1, `FBT_OFF_TC), 32'h0000ffff);
            rdc("reload", ad(i == 1, `FBT_OFF_TR), 32'h0);
            rdc("ctl", ad(i == 1, `FBT_OFF_CTL), 32'h0);
            rdc("int", ad(i == 1, `FBT_OFF_INT), 32'h0);
            rdc("div", ad(i == 1, `FBT_OFF_CLK), 32'h0);
        end
        rd(32'h0, d, r);
        chk("unmapped resp", {30'h0, r}, {30'h0, `FBT_RESP_SLVERR});
        wr(32'h0, 16'h0001, `FBT_RESP_SLVERR);
        wr(ad(0, `FBT_OFF_TC), 16'h1234);
        rdc("count ro", ad(0, `FBT_OFF_TC), 32'h0000ffff);
        $display("test reset and map done");
        for (i = 0; i < 4; i++) begin
            setup(ch_t[i], n_t[i], r_t[i], 16'h0000);
            wait_uf(ch_t[i], g);
            for (k = 0; k < 2; k++) begin
                wait_uf(ch_t[i], g);
                chk("period", g, (32'(r_t[i]) + 32'h1) << n_t[i]);
            end
        end
        wr(ad(1, `FBT_OFF_CTL), 16'h0000);
        setup(0, 4'hf, 16'h0003, 16'h0000);
        d = count0;
        repeat (100) @(posedge clk_in);
        chk("reserved div", count0, d);
        $display("test periods done");
        wr(ad(0, `FBT_OFF_INT), 16'h0001);
        setup(0, 4'h0, 16'h0003, 16'h0010);
        wait_uf(0, g);
        d = count0;
        repeat (20) @(posedge clk_in);
        chk("one shot", count0, d);
        rdc("ctl stop", ad(0, `FBT_OFF_CTL), 32'h00000010);
        rdc("reloaded", ad(0, `FBT_OFF_TC), 32'h00000003);
        rdc("flag", ad(0, `FBT_OFF_INT), 32'h00000001);
        chk("irq off", {30'h0, irq_out}, 32'h0);
        wr(ad(0, `FBT_OFF_INT), 16'h0101);
        chk("irq clr", {30'h0, irq_out}, 32'h0);
        rdc("flag clr", ad(0, `FBT_OFF_INT), 32'h00000100);
        wr(ad(0, `FBT_OFF_CTL), 16'h0001);
        wait_uf(0, g);
        chk("irq on", {30'h0, irq_out}, 32'h1);
        wr(ad(0, `FBT_OFF_CTL), 16'h0000);
        wr(ad(0, `FBT_OFF_INT), 16'h0101);
        chk("irq clr2", {30'h0, irq_out}, 32'h0);
        $display("test one shot and irq done");
        setup(0, 4'h0, 16'h0040, 16'h0000);
        repeat (10) @(posedge clk_in);
        wr(ad(0, `FBT_OFF_CTL), 16'h0000);
        rd(ad(0, `FBT_OFF_TC), d, r);
        repeat (20) @(posedge clk_in);
        rdc("held", ad(0, `FBT_OFF_TC), d);
        chk("moved", {31'h0, d < 32'h40}, 32'h1);
        wr(ad(0, `FBT_OFF_CTL), 16'h0002);
        rdc("preset", ad(0, `FBT_OFF_TC), 32'h00000040);
        rdc("preset reads 0", ad(0, `FBT_OFF_CTL), 32'h0);
        $display("test stop and preset done");
        for (i = 0; i < 16; i++) begin
            setup(0, 4'h0, 16'h0003, {4'h0, 4'(i), 8'h00});
            wait_uf(0, g);
            for (k = 1; k < 17; k++) begin
                wait_uf(0, g);
                chk("fine gap", g, 32'h4 + {31'h0, fine_mask[i][k % 16]});
            end
        end
        $display("test fine mode done");
        end_sim();
    end
endmodule

bind fbt_timer fbt_timer_properties u_props (.clk_in, .resetn_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in, .serial_clk_out,
    .underflow_out, .irq_out);
